// ---- rtl/pdc_pkg.sv ----
// Shared constants, settings layout and state encodings for the loop controller
package pdc_pkg;
  localparam int FB_W     = 8;
  localparam int FRAC_W   = 16;
  localparam int DIV_W    = 7;
  localparam int NUM_OUT  = 4;
  localparam int PEND_W   = 10;
  localparam int WB_AW    = 4;
  localparam int WB_DW    = 8;
  localparam int LOCK_WINDOWS = 8;

  // Sync vector positions
  localparam int SY_REF_A = 0;
  localparam int SY_REF_B = 1;
  localparam int SY_FB    = 2;
  localparam int SY_STEP  = 3;
  localparam int SY_N     = 4;

  // Reset values
  localparam logic [FB_W-1:0]    FB_INT_RESET  = 8'h01;
  localparam logic [FRAC_W-1:0]  FRAC_RESET    = 16'h0000;
  localparam logic [DIV_W-1:0]   DIV_RESET     = 7'h00;
  localparam logic [DIV_W-1:0]   PHASE_RESET   = 7'h00;
  localparam logic [NUM_OUT-1:0] CASCADE_RESET = 4'h0;

  // Configuration port addresses
  localparam logic [WB_AW-1:0] ADR_FB_INT  = 4'h0;
  localparam logic [WB_AW-1:0] ADR_FRAC_LO = 4'h1;
  localparam logic [WB_AW-1:0] ADR_FRAC_HI = 4'h2;
  localparam logic [WB_AW-1:0] ADR_DIV0    = 4'h3;
  localparam logic [WB_AW-1:0] ADR_PHASE1  = 4'h7;
  localparam logic [WB_AW-1:0] ADR_CASCADE = 4'ha;
  localparam logic [WB_AW-1:0] ADR_STATUS  = 4'hb;

  localparam logic PHASE_ADVANCE = 1'b1;

  typedef struct packed {
    logic [FB_W-1:0]                fb_int;
    logic [FRAC_W-1:0]              frac;
    logic [NUM_OUT-1:0][DIV_W-1:0]  div_code;
    logic [NUM_OUT-1:0][DIV_W-1:0]  phase_off;
    logic [NUM_OUT-1:0]             cascade;
  } pdc_settings_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [WB_AW-1:0] adr;
    logic [WB_DW-1:0] dat;
  } pdc_wb_req_t;

  // Gray codes along seek, count, locked
  typedef enum logic [1:0] {
    LK_SEEK  = 2'b00,
    LK_COUNT = 2'b01,
    LK_LOCK  = 2'b11
  } pdc_lock_state_t;
endpackage : pdc_pkg

// ---- rtl/pdc_divider.sv ----
// Output divider with phase offset load and single-step phase adjust
`timescale 1ns/10ps
module pdc_divider #(
  parameter int W = pdc_pkg::DIV_W
) (
  // Clock, reset, enable
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  // Tick stream
  input  wire logic         tick_in,
  output logic              tick_out,
  // Settings
  input  wire logic [W-1:0] div_code,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Phase steps
  input  wire logic         step_adv,
  input  wire logic         step_ret,
  // Divided clock level
  output logic              clk_out
);
  localparam logic [W:0] INC0 = (W+1)'(0);
  localparam logic [W:0] INC1 = (W+1)'(1);
  localparam logic [W:0] INC2 = (W+1)'(2);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic         adv_reg;
  logic         ret_reg;
  logic [W:0]   sum;
  logic [W:0]   half;
  logic         wrap;

  // Modulus is code+1, so any divide value 1..128 fits a 7-bit code
  always_comb begin
    sum  = {1'b0, count_reg} + (ret_reg ? INC0 : (adv_reg ? INC2 : INC1));
    half = ({1'b0, div_code} + INC1) >> 1;
    wrap = sum > {1'b0, div_code};
    if (div_code == '0) begin
      count_next = '0;
    end else if (wrap) begin
      count_next = W'(sum - {1'b0, div_code} - INC1);
    end else begin
      count_next = sum[W-1:0];
    end
  end

  assign tick_out = tick_in && ((div_code == '0) || wrap);

  // Counter; a reload restarts at the programmed offset, or at zero if it exceeds the code
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_reg <= '0;
    end else if (clk_en) begin
      if (load) begin
        count_reg <= (load_val <= div_code) ? load_val : '0;
      end else if (tick_in) begin
        count_reg <= count_next;
      end
    end
  end

  // Pending steps; a new step wins over the tick that consumes the old one
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      adv_reg <= 1'b0;
      ret_reg <= 1'b0;
    end else if (clk_en) begin
      adv_reg <= step_adv || (adv_reg && !tick_in);
      ret_reg <= step_ret || (ret_reg && !tick_in);
    end
  end

  // Divide by one can only show the tick itself as a level
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clk_out <= 1'b0;
    end else if (clk_en) begin
      if (div_code == '0) begin
        clk_out <= tick_in;
      end else if (tick_in && !load) begin
        clk_out <= {1'b0, count_next} < half;
      end
    end
  end

  property p_count_range;
    @(posedge sys_clk) disable iff (reset)
      !load |-> count_reg <= div_code;
  endproperty
  a_count_range: assert property (p_count_range) else $error("divider count out of range");

  property p_wrap;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && tick_in && !load && !adv_reg && !ret_reg && div_code != '0
       && count_reg == div_code) |-> tick_out ##1 (count_reg == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("divider did not wrap at code");

  property p_retard;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && tick_in && !load && ret_reg && !step_ret)
      |=> (count_reg == $past(count_reg)) && !ret_reg;
  endproperty
  a_retard: assert property (p_retard) else $error("retard step not applied once");
endmodule : pdc_divider

// ---- rtl/pdc_top.sv ----
// Loop controller: reference selection, fractional tick synthesis, dividers, lock, config
`timescale 1ns/10ps
// Behaviour
// - Each output divider divides by any whole value from 1 to 128.
// - Output dividers can be chained so one output's divided ticks feed the next.
// - Each of the four outputs has its own divider and can run at its own rate.
// - Lock rises when the loop judges itself locked and falls on any loss of lock.
// - The two-bit select picks which output takes dynamic phase steps.
// - The direction input decides whether a step advances or retards that output.
// - Each toggle of the step input moves the selected output by one step; toggles before its next input tick merge into one.
// - The three secondary outputs take a programmed phase offset against the primary.
// - Phase may change at run time; a step on the feedback output may drop lock.
// - User logic may switch the loop between two reference sources while running.
// - Settings are rewritten at run time over a WISHBONE port that needs the embedded unit.
// - The loop supports fractional-N synthesis with 16 bits of fraction.
// - The feedback divider sets the multiple of the reference rate.
// - Reference and feedback can each come from a pin or from internal routing.
// - Every output can drive the global clock network or general routing.
module pdc_top #(
  parameter int LOCK_WINDOWS = pdc_pkg::LOCK_WINDOWS
) (
  // Clock, reset, enable
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  // Reference and feedback
  input  wire logic                          reference_clock_in,
  input  wire logic                          reference_clock_alt_in,
  input  wire logic                          reference_internal_in,
  input  wire logic                          reference_source_switch,
  input  wire logic                          ref_from_internal,
  input  wire logic                          feedback_clock_in,
  input  wire logic                          fb_from_internal,
  // Dynamic phase
  input  wire logic [1:0]                    phase_output_select,
  input  wire logic                          phase_direction,
  input  wire logic                          phase_step_toggle,
  // WISHBONE configuration port
  input  wire logic                          embedded_function_unit_present,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [pdc_pkg::WB_AW-1:0]     wb_adr_i,
  input  wire logic [pdc_pkg::WB_DW-1:0]     wb_dat_i,
  output logic      [pdc_pkg::WB_DW-1:0]     wb_dat_o,
  output logic                               wb_ack_o,
  // Output clocks and network steering
  input  wire logic [pdc_pkg::NUM_OUT-1:0]   out_to_global,
  output logic                               primary_clock_out,
  output logic                               secondary_clock_out_a,
  output logic                               secondary_clock_out_b,
  output logic                               secondary_clock_out_c,
  output logic      [pdc_pkg::NUM_OUT-1:0]   clk_global_out,
  output logic      [pdc_pkg::NUM_OUT-1:0]   clk_route_out,
  // Status
  output logic                               lock
);
  localparam int N   = pdc_pkg::NUM_OUT;
  localparam int AW  = pdc_pkg::PEND_W + pdc_pkg::FRAC_W;
  localparam logic [AW-1:0] TICK_ONE = AW'(1) << pdc_pkg::FRAC_W;

  logic [pdc_pkg::SY_N-1:0] sync1_reg;
  logic [pdc_pkg::SY_N-1:0] sync2_reg;
  logic                     ref_prev_reg;
  logic                     fb_prev_reg;
  logic                     step_prev_reg;
  logic [1:0]               src_prev_reg;
  logic                     ref_lvl;
  logic                     fb_lvl;
  logic                     ref_rise;
  logic                     fb_rise;
  logic                     step_evt;
  logic                     src_change;
  logic                     disturb;
  pdc_pkg::pdc_settings_t   set_reg;
  pdc_pkg::pdc_wb_req_t     req;
  logic                     hit;
  logic                     wr;
  logic                     load_reg;
  logic [pdc_pkg::WB_DW-1:0] rd_data;
  logic [AW-1:0]            acc_reg;
  logic [AW-1:0]            inc;
  logic                     vco_tick;
  logic [N-1:0]             tick_src;
  logic [N-1:0]             tick_o;
  logic [N-1:0]             out_clk;
  logic [N-1:0]             step_adv;
  logic [N-1:0]             step_ret;
  pdc_pkg::pdc_lock_state_t lk_state_reg;
  logic [7:0]               lock_cnt_reg;
  logic [1:0]               fb_cnt_reg;
  logic                     window_good;

  // Pins from other clocks pass two flops before anything looks at them
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= {phase_step_toggle, feedback_clock_in,
                    reference_clock_alt_in, reference_clock_in};
      sync2_reg <= sync1_reg;
    end
  end

  // Source muxing; internal sources are already on this clock
  assign ref_lvl = ref_from_internal ? reference_internal_in :
                   (reference_source_switch ? sync2_reg[pdc_pkg::SY_REF_B]
                                            : sync2_reg[pdc_pkg::SY_REF_A]);
  assign fb_lvl  = fb_from_internal ? out_clk[0] : sync2_reg[pdc_pkg::SY_FB];

  // Previous samples for edge and change detection
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ref_prev_reg  <= 1'b0;
      fb_prev_reg   <= 1'b0;
      step_prev_reg <= 1'b0;
      src_prev_reg  <= 2'h0;
    end else if (clk_en) begin
      ref_prev_reg  <= ref_lvl;
      fb_prev_reg   <= fb_lvl;
      step_prev_reg <= sync2_reg[pdc_pkg::SY_STEP];
      src_prev_reg  <= {ref_from_internal, reference_source_switch};
    end
  end

  assign ref_rise   = ref_lvl && !ref_prev_reg;
  assign fb_rise    = fb_lvl && !fb_prev_reg;
  assign step_evt   = sync2_reg[pdc_pkg::SY_STEP] ^ step_prev_reg;
  assign src_change = {ref_from_internal, reference_source_switch} != src_prev_reg;

  // Configuration slave; without the embedded unit nothing is acknowledged
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, dat: wb_dat_i};
  assign hit = req.cyc && req.stb && embedded_function_unit_present && !wb_ack_o;
  assign wr  = hit && req.we;

  // Settings store; a write reloads dividers and drops lock
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      set_reg <= '{fb_int: pdc_pkg::FB_INT_RESET, frac: pdc_pkg::FRAC_RESET,
                   div_code: {N{pdc_pkg::DIV_RESET}}, phase_off: {N{pdc_pkg::PHASE_RESET}},
                   cascade: pdc_pkg::CASCADE_RESET};
      load_reg <= 1'b0;
    end else if (clk_en) begin
      load_reg <= wr;
      if (wr) begin
        if (req.adr == pdc_pkg::ADR_FB_INT) begin
          set_reg.fb_int <= req.dat;
        end else if (req.adr == pdc_pkg::ADR_FRAC_LO) begin
          set_reg.frac[7:0] <= req.dat;
        end else if (req.adr == pdc_pkg::ADR_FRAC_HI) begin
          set_reg.frac[15:8] <= req.dat;
        end else if (req.adr >= pdc_pkg::ADR_DIV0 && req.adr < pdc_pkg::ADR_PHASE1) begin
          set_reg.div_code[2'(req.adr - pdc_pkg::ADR_DIV0)] <= req.dat[6:0];
        end else if (req.adr >= pdc_pkg::ADR_PHASE1 && req.adr < pdc_pkg::ADR_CASCADE) begin
          set_reg.phase_off[2'(req.adr - pdc_pkg::ADR_PHASE1) + 2'h1] <= req.dat[6:0];
        end else if (req.adr == pdc_pkg::ADR_CASCADE) begin
          set_reg.cascade <= req.dat[N-1:0];
        end
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_data = '0;
    if (req.adr == pdc_pkg::ADR_FB_INT) begin
      rd_data = set_reg.fb_int;
    end else if (req.adr == pdc_pkg::ADR_FRAC_LO) begin
      rd_data = set_reg.frac[7:0];
    end else if (req.adr == pdc_pkg::ADR_FRAC_HI) begin
      rd_data = set_reg.frac[15:8];
    end else if (req.adr >= pdc_pkg::ADR_DIV0 && req.adr < pdc_pkg::ADR_PHASE1) begin
      rd_data = {1'b0, set_reg.div_code[2'(req.adr - pdc_pkg::ADR_DIV0)]};
    end else if (req.adr >= pdc_pkg::ADR_PHASE1 && req.adr < pdc_pkg::ADR_CASCADE) begin
      rd_data = {1'b0, set_reg.phase_off[2'(req.adr - pdc_pkg::ADR_PHASE1) + 2'h1]};
    end else if (req.adr == pdc_pkg::ADR_CASCADE) begin
      rd_data = {4'h0, set_reg.cascade};
    end else if (req.adr == pdc_pkg::ADR_STATUS) begin
      rd_data = {4'h0, fb_from_internal, ref_from_internal, reference_source_switch, lock};
    end
  end

  // One-cycle acknowledge, read data held until the next read
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (clk_en) begin
      wb_ack_o <= hit;
      if (hit && !req.we) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // Fractional tick credit: each reference edge adds N.F ticks, one drains per cycle
  assign inc      = {{(pdc_pkg::PEND_W - pdc_pkg::FB_W){1'b0}}, set_reg.fb_int, set_reg.frac};
  assign vco_tick = |acc_reg[AW-1:pdc_pkg::FRAC_W];
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      acc_reg <= '0;
    end else if (clk_en) begin
      // Top bit blocks further credit so the pending count cannot wrap
      acc_reg <= acc_reg - (vco_tick ? TICK_ONE : '0)
                 + ((ref_rise && !acc_reg[AW-1]) ? inc : '0);
    end
  end

  // Per-output dividers, optionally fed from the previous one
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_out
      if (i == 0) begin : g_first
        assign tick_src[i] = vco_tick;
      end else begin : g_chain
        assign tick_src[i] = set_reg.cascade[i] ? tick_o[i-1] : vco_tick;
      end
      assign step_adv[i] = step_evt && (phase_output_select == 2'(i))
                           && (phase_direction == pdc_pkg::PHASE_ADVANCE);
      assign step_ret[i] = step_evt && (phase_output_select == 2'(i))
                           && (phase_direction != pdc_pkg::PHASE_ADVANCE);
      pdc_divider #(.W(pdc_pkg::DIV_W)) u_div (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .tick_in  (tick_src[i]),
        .tick_out (tick_o[i]),
        .div_code (set_reg.div_code[i]),
        .load     (load_reg),
        .load_val (set_reg.phase_off[i]),
        .step_adv (step_adv[i]),
        .step_ret (step_ret[i]),
        .clk_out  (out_clk[i])
      );
    end
  endgenerate

  assign primary_clock_out     = out_clk[0];
  assign secondary_clock_out_a = out_clk[1];
  assign secondary_clock_out_b = out_clk[2];
  assign secondary_clock_out_c = out_clk[3];

  // Network steering costs one cycle but keeps the outputs glitch free
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clk_global_out <= '0;
      clk_route_out  <= '0;
    end else if (clk_en) begin
      clk_global_out <= out_clk & out_to_global;
      clk_route_out  <= out_clk & ~out_to_global;
    end
  end

  // Config writes, reference source changes and feedback-output steps restart lock qualification
  assign disturb = wr || src_change ||
                   (step_evt && fb_from_internal && phase_output_select == 2'h0);
  assign window_good = (fb_cnt_reg == 2'h1 && !fb_rise) || (fb_cnt_reg == 2'h0 && fb_rise);

  // Feedback edges seen in the current reference period, saturating
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fb_cnt_reg <= 2'h0;
    end else if (clk_en) begin
      if (ref_rise) begin
        fb_cnt_reg <= 2'h0;
      end else if (fb_rise && fb_cnt_reg != 2'h3) begin
        fb_cnt_reg <= fb_cnt_reg + 2'h1;
      end
    end
  end

  // Lock needs a run of clean reference periods; one bad period drops it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lk_state_reg <= pdc_pkg::LK_SEEK;
      lock_cnt_reg <= 8'h00;
      lock         <= 1'b0;
    end else if (clk_en) begin
      if (disturb) begin
        lk_state_reg <= pdc_pkg::LK_SEEK;
        lock_cnt_reg <= 8'h00;
        lock         <= 1'b0;
      end else if (ref_rise) begin
        unique case (lk_state_reg)
          pdc_pkg::LK_SEEK: begin
            lk_state_reg <= pdc_pkg::LK_COUNT;
            lock_cnt_reg <= 8'h00;
          end
          pdc_pkg::LK_COUNT: begin
            if (!window_good) begin
              lock_cnt_reg <= 8'h00;
            end else if (lock_cnt_reg == 8'(LOCK_WINDOWS - 1)) begin
              lk_state_reg <= pdc_pkg::LK_LOCK;
              lock         <= 1'b1;
            end else begin
              lock_cnt_reg <= lock_cnt_reg + 8'h01;
            end
          end
          pdc_pkg::LK_LOCK: begin
            if (!window_good) begin
              lk_state_reg <= pdc_pkg::LK_SEEK;
              lock         <= 1'b0;
            end
          end
          default: begin
            lk_state_reg <= pdc_pkg::LK_SEEK;
            lock         <= 1'b0;
          end
        endcase
      end
    end
  end

  property p_wb_ack;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && hit) |=> wb_ack_o ##1 (!wb_ack_o || !$past(clk_en));
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("config access not acknowledged once");

  property p_no_efu;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && !embedded_function_unit_present) |=> !wb_ack_o;
  endproperty
  a_no_efu: assert property (p_no_efu) else $error("ack without embedded unit");

  property p_lock_drop;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && disturb) |=> !lock && lk_state_reg == pdc_pkg::LK_SEEK;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock kept after disturbance");

  property p_lock_rise;
    @(posedge sys_clk) disable iff (reset)
      $rose(lock) |-> $past(lock_cnt_reg) == 8'(LOCK_WINDOWS - 1) && $past(window_good);
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose without full run");

  property p_step_route;
    @(posedge sys_clk) disable iff (reset)
      step_evt |-> ((step_adv | step_ret) == (4'h1 << phase_output_select))
                   && ((step_adv != '0) == (phase_direction == pdc_pkg::PHASE_ADVANCE));
  endproperty
  a_step_route: assert property (p_step_route) else $error("phase step misrouted");

  property p_step_once;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && step_evt) ##1 (clk_en && $stable(sync2_reg[pdc_pkg::SY_STEP])) |-> !step_evt;
  endproperty
  a_step_once: assert property (p_step_once) else $error("one toggle gave two steps");

  property p_nco;
    @(posedge sys_clk) disable iff (reset)
      (clk_en && ref_rise && !acc_reg[AW-1] && !vco_tick)
      |=> acc_reg == $past(acc_reg) + $past(inc);
  endproperty
  a_nco: assert property (p_nco) else $error("reference edge did not add N.F credit");
endmodule : pdc_top

// ---- tb/pdc_clock_source.sv ----
// Reference and feedback clock source at the loop's far side
`timescale 1ns/10ps
module pdc_clock_source #(
  parameter int HALF = 4
) (
  // Clock and control
  input  wire logic sys_clk,
  input  wire logic fb_enable,
  // Clock levels toward the loop
  output logic      ref_clk,
  output logic      fb_clk
);
  int cnt = 0;
  initial ref_clk = 1'b0;
  initial fb_clk = 1'b0;
  // Feedback follows the reference, one edge a period; held low it starves the lock check
  always @(posedge sys_clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      ref_clk <= ~ref_clk;
      fb_clk  <= fb_enable ? ~ref_clk : 1'b0;
    end
  end
endmodule : pdc_clock_source

// ---- tb/pdc_top_tb_top.sv ----
// Self-checking bench for the loop controller
`timescale 1ns/10ps
module pdc_top_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic ref_sw = 1'b0;
  logic ref_int = 1'b0;
  logic fb_en = 1'b1;
  logic ref_clk, fb_clk, ack, lock;
  logic [1:0] psel = 2'h0;
  logic pdir = 1'b0;
  logic ptog = 1'b0;
  logic [3:0] glob = 4'h0;
  logic cen = 1'b1;
  logic efu = 1'b1;
  logic fb_sel = 1'b0;
  logic prim, sec_a, sec_b, sec_c;
  logic [3:0] gout, rout;
  logic [3:0] oc;
  pdc_pkg::pdc_wb_req_t req = '0;
  logic [7:0] dat_o;
  logic [8:0] exp_q[$];
  logic [8:0] ent;
  int n_errors = 0;
  int n_checks = 0;
  logic [31:0] rnd = 32'h89d2;

  always #50 sys_clk = ~sys_clk;

  pdc_clock_source SRC (.sys_clk(sys_clk), .fb_enable(fb_en), .ref_clk(ref_clk),
    .fb_clk(fb_clk));
  pdc_top #(.LOCK_WINDOWS(2)) DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(cen),
    .reference_clock_in(ref_clk), .reference_clock_alt_in(ref_clk),
    .reference_internal_in(ref_clk), .reference_source_switch(ref_sw),
    .ref_from_internal(ref_int), .feedback_clock_in(fb_clk), .fb_from_internal(fb_sel),
    .phase_output_select(psel), .phase_direction(pdir), .phase_step_toggle(ptog),
    .embedded_function_unit_present(efu), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .out_to_global(glob), .primary_clock_out(prim),
    .secondary_clock_out_a(sec_a), .secondary_clock_out_b(sec_b),
    .secondary_clock_out_c(sec_c), .clk_global_out(gout), .clk_route_out(rout),
    .lock(lock));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // One classic cycle; request held until ack is sampled, then a spare edge
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d,
                    input logic [7:0] e);
    int i;
    exp_q.push_back({we, e});
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, dat: d};
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      n_errors++;
      results();
    end
    req <= '0;
    @(posedge sys_clk);
  endtask : wb

  task automatic wait_lock(input logic lvl);
    int i;
    for (i = 0; i < 400 && lock !== lvl; i++) @(posedge sys_clk);
    check("lock", {7'h00, lock}, {7'h00, lvl});
    if (lock !== lvl) results();
  endtask : wait_lock

  // Read results are taken off the note queue as each ack shows
  always @(posedge sys_clk) begin
    if (ack === 1'b1 && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      if (!ent[8]) check("wb read", dat_o, ent[7:0]);
    end
  end

  initial begin
    logic [7:0] d;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    wb(0, pdc_pkg::ADR_FB_INT, 8'h00, pdc_pkg::FB_INT_RESET);
    wb(0, 4'hc, 8'h00, 8'h00);
    wb(1, pdc_pkg::ADR_FRAC_LO, 8'h3c, 8'h00);
    wb(1, pdc_pkg::ADR_FRAC_HI, 8'ha5, 8'h00);
    wb(0, pdc_pkg::ADR_FRAC_LO, 8'h00, 8'h3c);
    wb(0, pdc_pkg::ADR_FRAC_HI, 8'h00, 8'ha5);
    wb(1, pdc_pkg::ADR_PHASE1, 8'h05, 8'h00);
    wb(0, pdc_pkg::ADR_PHASE1, 8'h00, 8'h05);
    wb(1, pdc_pkg::ADR_CASCADE, 8'h0e, 8'h00);
    wb(0, pdc_pkg::ADR_CASCADE, 8'h00, 8'h0e);
    // Divide codes: 128, 1, then random, each output's code written then read back
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      d = (k == 0) ? 8'h7f : (k == 1) ? 8'h00 : {1'b0, rnd[6:0]};
      wb(1, pdc_pkg::ADR_DIV0 + 4'(k), d, 8'h00);
      wb(0, pdc_pkg::ADR_DIV0 + 4'(k), 8'h00, d);
    end
    wait_lock(1'b1);
    fb_en <= 1'b0;
    wait_lock(1'b0);
    fb_en <= 1'b1;
    wait_lock(1'b1);
    wb(1, pdc_pkg::ADR_FB_INT, 8'h01, 8'h00);
    check("lock after write", {7'h00, lock}, 8'h00);
    // A frozen enable or a missing unit must leave a pending write unanswered
    cen <= 1'b0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: 1'b1, adr: pdc_pkg::ADR_FB_INT, dat: 8'h07};
    repeat (4) @(posedge sys_clk);
    check("ack while frozen", {7'h00, ack}, 8'h00);
    cen <= 1'b1;
    efu <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check("ack without unit", {7'h00, ack}, 8'h00);
    req <= '0;
    efu <= 1'b1;
    @(posedge sys_clk);
    wb(0, pdc_pkg::ADR_FB_INT, 8'h00, 8'h01);
    ref_sw <= 1'b1;
    ref_int <= 1'b1;
    fb_sel <= 1'b1;
    repeat (2) @(posedge sys_clk);
    wb(0, pdc_pkg::ADR_STATUS, 8'h00, 8'h0e);
    // User logic toggles once for each wanted step, steps spaced apart
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      psel <= rnd[1:0];
      pdir <= rnd[2];
      glob <= rnd[6:3];
      ptog <= ~ptog;
      repeat (40) @(posedge sys_clk);
      // Steering is registered, so compare against the levels one edge earlier
      oc = {sec_c, sec_b, sec_a, prim};
      @(posedge sys_clk);
      check("global net", {4'h0, gout}, {4'h0, oc & glob});
      check("general route", {4'h0, rout}, {4'h0, oc & ~glob});
    end
    results();
  end
endmodule : pdc_top_tb_top
